// file: sim/tb.sv
// Testbench of the timer/counter: APB tasks and directed tests.
// Assumes an APB slave that answers within 20 cycles and the pin model beside it.
`timescale 1ns/100ps
`default_nettype none

module tb
    import tmrcnt_pkg::*;
;
    logic        pclk = 1'h0;
    logic        presetn = 1'h0;
    logic        psel = 1'h0;
    logic        penable = 1'h0;
    logic        pwrite = 1'h0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        ext_count_in;
    logic        sleep_in = 1'h0;
    logic        match_pulse_output;
    logic        event_flag;
    logic        go = 1'h0;
    logic        busy;
    logic [7:0]  n_edges = 8'h00;
    logic [31:0] q;
    logic        e;
    int          n_mismatch = 0;
    int          checked = 0;
    int          cyc = 0;
    int          w;
    int          p;

    always #5 pclk = ~pclk;
    always @(posedge pclk) cyc <= cyc + 1;

    tmrcnt_top tmrcnt_top_inst (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ext_count_in(ext_count_in),
        .sleep_in(sleep_in), .match_pulse_output(match_pulse_output),
        .event_flag(event_flag));
    tmrcnt_pin_model tmrcnt_pin_model_inst (.pclk(pclk), .go(go),
        .edges(n_edges), .pin(ext_count_in), .busy(busy));

    task automatic print_verdict;
        $display("checked %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : print_verdict

    task automatic chk(input string nm, input logic [31:0] s, x);
        checked++;
        if (s !== x) begin
            n_mismatch++;
            $display("FAIL %s expected %h seen %h", nm, x, s);
        end
    endtask : chk

    task automatic tmo;
        chk("wait", 32'h1, 32'h0);
        print_verdict;
    endtask : tmo

    task automatic xfer(input logic wr, input logic [7:0] a,
                        input logic [31:0] d);
        int i;
        @(posedge pclk);
        psel <= 1'h1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        for (i = 0; i < 20; i++) begin
            @(posedge pclk);
            if (pready === 1'h1) break;
        end
        if (i == 20) tmo;
        q = prdata;
        e = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask : xfer

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'h1, a, d);
    endtask : wr

    task automatic rd(input string nm, input logic [7:0] a,
                      input logic [31:0] x);
        xfer(1'h0, a, 32'h0);
        chk(nm, q, x);
    endtask : rd

    // Sends k rising edges on the pin and lets the synchroniser settle.
    task automatic pins(input logic [7:0] k);
        int i;
        @(posedge pclk);
        n_edges <= k;
        go <= 1'h1;
        @(posedge pclk);
        go <= 1'h0;
        for (i = 0; i < 2000; i++) begin
            @(posedge pclk);
            if (busy === 1'h0) break;
        end
        if (i == 2000) tmo;
        repeat (12) @(posedge pclk);
    endtask : pins

    task automatic lvl(input logic v);
        int i;
        for (i = 0; i < 2000 && match_pulse_output !== v; i++)
            @(posedge pclk);
        if (i == 2000) tmo;
    endtask : lvl

    // Width and period of the next output pulse, in pclk cycles.
    task automatic pulse;
        int t0;
        lvl(1'h0);
        lvl(1'h1);
        t0 = cyc;
        lvl(1'h0);
        w = cyc - t0;
        lvl(1'h1);
        p = cyc - t0;
    endtask : pulse

    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'h1;
        rd("low", OFS_COUNT_LOW, 32'h0);
        rd("high", OFS_COUNT_HIGH, 32'hff);
        rd("unmapped", 8'h14, 32'h0);
        chk("slverr", e, 32'h1);
        wr(OFS_COUNT_HIGH, 32'h5a);
        rd("high", OFS_COUNT_HIGH, 32'h5a);
        wr(OFS_COUNT_LOW, 32'h22);
        rd("low", OFS_COUNT_LOW, 32'h22);
        $display("test reset and direct access done");
        wr(OFS_CTRL_FIRST, 32'h10);
        wr(OFS_COUNT_HIGH, 32'h12);
        wr(OFS_COUNT_LOW, 32'h34);
        rd("low", OFS_COUNT_LOW, 32'h34);
        rd("high", OFS_COUNT_HIGH, 32'h12);
        wr(OFS_COUNT_HIGH, 32'h56);
        rd("low", OFS_COUNT_LOW, 32'h34);
        rd("high", OFS_COUNT_HIGH, 32'h12);
        $display("test wide buffer done");
        wr(OFS_COUNT_HIGH, 32'h0);
        wr(OFS_COUNT_LOW, 32'h0);
        wr(OFS_CTRL_SECOND, 32'h10);
        wr(OFS_CTRL_FIRST, 32'h90);
        sleep_in <= 1'h1;
        pins(8'h05);
        rd("async", OFS_COUNT_LOW, 32'h5);
        wr(OFS_CTRL_SECOND, 32'h00);
        pins(8'h03);
        rd("sync sleep", OFS_COUNT_LOW, 32'h5);
        sleep_in <= 1'h0;
        pins(8'h03);
        rd("sync", OFS_COUNT_LOW, 32'h8);
        wr(OFS_CTRL_SECOND, 32'h30);
        pins(8'h02);
        rd("falling", OFS_COUNT_LOW, 32'ha);
        wr(OFS_CTRL_SECOND, 32'hf0);
        pins(8'h02);
        rd("no source", OFS_COUNT_LOW, 32'ha);
        $display("test pin counting done");
        wr(OFS_CTRL_FIRST, 32'h00);
        wr(OFS_COUNT_HIGH, 32'h3);
        wr(OFS_COUNT_LOW, 32'h0);
        wr(OFS_CTRL_SECOND, 32'h40);
        wr(OFS_CTRL_FIRST, 32'h80);
        pulse;
        chk("width", w, 32'h1);
        chk("period", p, 32'h4);
        wr(OFS_CTRL_SECOND, 32'h42);
        pulse;
        chk("width", w, 32'h4);
        chk("period", p, 32'h10);
        wr(OFS_COUNT_HIGH, 32'h1);
        pulse;
        pulse;
        chk("reload", p, 32'h8);
        chk("flag", event_flag, 32'h1);
        wr(OFS_CTRL_SECOND, 32'h60);
        rd("ctrl2", OFS_CTRL_SECOND, 32'h60);
        pulse;
        chk("instr width", w, 32'h4);
        chk("instr period", p, 32'h8);
        wr(OFS_CTRL_FIRST, 32'h81);
        pulse;
        chk("post width", w, 32'h4);
        chk("post period", p, 32'h10);
        wr(OFS_CTRL_FIRST, 32'h00);
        wr(OFS_STATUS, 32'h1);
        rd("status", OFS_STATUS, 32'h0);
        chk("out off", match_pulse_output, 32'h0);
        $display("test period compare done");
        @(posedge pclk);
        presetn <= 1'h0;
        repeat (3) @(posedge pclk);
        presetn <= 1'h1;
        rd("low", OFS_COUNT_LOW, 32'h0);
        rd("high", OFS_COUNT_HIGH, 32'hff);
        $display("test second reset done");
        print_verdict;
    end
endmodule : tb

`default_nettype wire

// file: sim/tmrcnt_pin_model.sv
// Model of the source that drives the external count pin.
// Assumes a request is a one-cycle go pulse with the edge count held.
`timescale 1ns/100ps
`default_nettype none

module tmrcnt_pin_model (
    // Clock.
    input  wire logic       pclk,
    // Request.
    input  wire logic       go,
    input  wire logic [7:0] edges,
    // Pin and state.
    output logic            pin,
    output logic            busy
);
    initial begin
        pin = 1'h0;
        busy = 1'h0;
    end

    // Pulses of 4 high and 4 low cycles stay inside the sync limit.
    always begin
        @(posedge pclk);
        if (go) begin
            busy <= 1'h1;
            repeat (edges) begin
                repeat (4) @(posedge pclk);
                pin <= 1'h1;
                repeat (4) @(posedge pclk);
                pin <= 1'h0;
            end
            @(posedge pclk);
            busy <= 1'h0;
        end
    end
endmodule : tmrcnt_pin_model

`default_nettype wire

// file: verilog/tmrcnt_pkg.sv
// Package of the 8/16-bit timer/counter: register map, field layout,
// reset values and divider counts.
// Assumes an APB slave with 32-bit data; every register is one word.
package tmrcnt_pkg;

    // Register byte offsets.
    localparam logic [7:0] OFS_CTRL_FIRST  = 8'h00;
    localparam logic [7:0] OFS_CTRL_SECOND = 8'h04;
    localparam logic [7:0] OFS_COUNT_LOW   = 8'h08;
    localparam logic [7:0] OFS_COUNT_HIGH  = 8'h0c;
    localparam logic [7:0] OFS_STATUS      = 8'h10;

    // Field positions.
    localparam int STATUS_FLAG_BIT = 0;

    // Values after reset.
    localparam logic [7:0] RST_COUNT_LOW  = 8'h00;
    localparam logic [7:0] RST_COUNT_HIGH = 8'hff;
    localparam logic [7:0] RST_CTRL       = 8'h00;

    // Count source codes of the source select field.
    localparam logic [2:0] SRC_EXT_RISE = 3'h0;
    localparam logic [2:0] SRC_EXT_FALL = 3'h1;
    localparam logic [2:0] SRC_FOSC     = 3'h2;
    localparam logic [2:0] SRC_INSTR    = 3'h3;

    // Last count of the system clock divider in each instruction cycle.
    localparam logic [1:0] INSTR_DIV_LAST = 2'h3;

    // First control register.
    typedef struct packed {
        logic       enable;
        logic       unused6;
        logic       out_state;
        logic       wide_count_select;
        logic [3:0] postscale;
    } tmrcnt_ctrl1_s;

    // Second control register.
    typedef struct packed {
        logic [2:0] count_source_select;
        logic       async_count_select;
        logic [3:0] prescale_ratio_field;
    } tmrcnt_ctrl2_s;

endpackage : tmrcnt_pkg

// file: verilog/tmrcnt_top.sv
// Timer/counter with a 15-bit prescaler, 4-bit postscaler, 8-bit period
// compare mode and 16-bit mode with a buffered high byte, on APB.
// Assumes the count pin is asynchronous to pclk and sleep_in comes from
// logic on pclk.
//
// Implementation choices: the APB register port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none

module tmrcnt_top
    import tmrcnt_pkg::*;
(
    // Clock and reset.
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave.
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Count input pin and sleep state.
    input  wire logic        ext_count_in,
    input  wire logic        sleep_in,
    // Outputs.
    output logic             match_pulse_output,
    output logic             event_flag
);

    // Low bits mask of a prescale ratio of two to the power n.
    function automatic logic [14:0] ps_mask(input logic [3:0] n);
        logic [15:0] one_hot;
        one_hot = 16'h0001 << n;
        return 15'(one_hot - 16'h0001);
    endfunction : ps_mask

    tmrcnt_ctrl1_s ctrl1_reg;
    tmrcnt_ctrl2_s ctrl2_reg;
    logic [7:0]    low_reg;
    logic [7:0]    high_buf_reg;
    logic [7:0]    cnt_hi_reg;
    logic [7:0]    period_reg;
    logic [14:0]   presc_reg;
    logic [3:0]    post_reg;
    logic          out_reg;
    logic          flag_reg;
    logic [1:0]    div_reg;
    logic          pend_reg;
    logic          ext_s1_reg;
    logic          ext_s2_reg;
    logic          ext_s3_reg;
    logic [31:0]   rdata_reg;

    // Bus decode.
    wire setup    = psel & ~penable;
    wire access   = psel & penable;
    wire sel_c1   = paddr == OFS_CTRL_FIRST;
    wire sel_c2   = paddr == OFS_CTRL_SECOND;
    wire sel_lo   = paddr == OFS_COUNT_LOW;
    wire sel_hi   = paddr == OFS_COUNT_HIGH;
    wire sel_st   = paddr == OFS_STATUS;
    wire addr_hit = sel_c1 | sel_c2 | sel_lo | sel_hi | sel_st;
    wire wr       = access & pwrite & addr_hit;
    wire wr_c1    = wr & sel_c1;
    wire wr_c2    = wr & sel_c2;
    wire wr_lo    = wr & sel_lo;
    wire wr_hi    = wr & sel_hi;
    wire wr_st    = wr & sel_st;
    wire rd_lo    = setup & ~pwrite & sel_lo;
    wire wide     = ctrl1_reg.wide_count_select;

    assign pready  = 1'b1;
    assign pslverr = access & ~addr_hit;
    assign prdata  = rdata_reg;

    // Instruction cycle enable from the system clock divider.
    wire instr_en = div_reg == INSTR_DIV_LAST;

    // Source selection and synchronous alignment.
    wire ext_rise = ext_s2_reg & ~ext_s3_reg;
    wire ext_fall = ~ext_s2_reg & ext_s3_reg;
    wire [2:0] src_sel = ctrl2_reg.count_source_select;
    wire is_ext = (src_sel == SRC_EXT_RISE) | (src_sel == SRC_EXT_FALL);
    wire async_on = ctrl2_reg.async_count_select;
    wire ext_edge = (src_sel == SRC_EXT_RISE) ? ext_rise : ext_fall;
    wire int_tick = (src_sel == SRC_FOSC) |
                    ((src_sel == SRC_INSTR) & instr_en);
    // Sync mode holds an edge until the next instruction cycle, so the
    // count rate can never exceed the instruction rate.
    wire sync_ext = (pend_reg | ext_edge) & instr_en;
    wire ext_tick = async_on ? ext_edge : sync_ext;
    wire sel_tick = is_ext ? ext_tick : int_tick;
    wire count_ok = ctrl1_reg.enable &
                    (~sleep_in | (async_on & is_ext));
    wire src_tick = count_ok & sel_tick;

    // Prescaler.
    wire [14:0] pmask = ps_mask(ctrl2_reg.prescale_ratio_field);
    wire pre_tick = src_tick & ((presc_reg & pmask) == pmask);
    wire clr_scale = wr_lo | wr_c1 | wr_c2;

    // Counter events and postscaler.
    wire [15:0] cnt16 = {cnt_hi_reg, low_reg};
    wire match8 = low_reg == period_reg;
    wire wrap16 = cnt16 == 16'hffff;
    wire cnt_evt = pre_tick & (wide ? wrap16 : match8);
    wire post_hit = cnt_evt & (post_reg == ctrl1_reg.postscale);
    wire [15:0] cnt16_inc = cnt16 + 16'h0001;
    wire flag_clr = wr_st & pwdata[STATUS_FLAG_BIT];

    // Read data selection.
    wire [7:0] rd_byte =
        sel_c1 ? {ctrl1_reg.enable, 1'b0, out_reg, ctrl1_reg[4:0]} :
        sel_c2 ? ctrl2_reg :
        sel_lo ? low_reg :
        sel_hi ? high_buf_reg :
        sel_st ? {7'h00, flag_reg} : 8'h00;

    assign match_pulse_output = out_reg;
    assign event_flag         = flag_reg;

    // Pin synchroniser; the first stage feeds only the second.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_s1_reg <= 1'b0;
            ext_s2_reg <= 1'b0;
            ext_s3_reg <= 1'b0;
        end else begin
            ext_s1_reg <= ext_count_in;
            ext_s2_reg <= ext_s1_reg;
            ext_s3_reg <= ext_s2_reg;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_reg  <= 2'h0;
            pend_reg <= 1'b0;
        end else begin
            div_reg  <= div_reg + 2'h1;
            // Only sync mode may hold an edge, so a later switch out of
            // async mode cannot replay a stale edge.
            pend_reg <= (pend_reg | ext_edge) & ~instr_en & is_ext
                        & ~async_on;
        end
    end

    // Control and status registers.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl1_reg <= tmrcnt_ctrl1_s'(RST_CTRL);
            ctrl2_reg <= tmrcnt_ctrl2_s'(RST_CTRL);
            flag_reg  <= 1'b0;
            rdata_reg <= 32'h0000_0000;
        end else begin
            if (wr_c1) begin
                ctrl1_reg <= tmrcnt_ctrl1_s'({pwdata[7], 2'b00,
                                              pwdata[4:0]});
            end
            if (wr_c2) begin
                ctrl2_reg <= tmrcnt_ctrl2_s'(pwdata[7:0]);
            end
            // A pulse in the clearing cycle keeps the flag set.
            flag_reg <= post_hit | (flag_reg & ~flag_clr);
            if (setup) begin
                rdata_reg <= {24'h000000, rd_byte};
            end
        end
    end

    // Prescaler and postscaler counters.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            presc_reg <= 15'h0000;
            post_reg  <= 4'h0;
        end else if (clr_scale) begin
            presc_reg <= 15'h0000;
            post_reg  <= 4'h0;
        end else begin
            if (src_tick) begin
                presc_reg <= pre_tick ? 15'h0000 : presc_reg + 15'h0001;
            end
            if (cnt_evt) begin
                post_reg <= post_hit ? 4'h0 : post_reg + 4'h1;
            end
        end
    end

    // Output pulse: one prescaled period long.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_reg <= 1'b0;
        end else if (post_hit) begin
            out_reg <= 1'b1;
        end else if (pre_tick | ~ctrl1_reg.enable) begin
            out_reg <= 1'b0;
        end
    end

    // Count registers. A software write wins over a count in that cycle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            low_reg      <= RST_COUNT_LOW;
            high_buf_reg <= RST_COUNT_HIGH;
            cnt_hi_reg   <= RST_COUNT_LOW;
            period_reg   <= RST_COUNT_HIGH;
        end else begin
            if (wr_lo) begin
                low_reg <= pwdata[7:0];
                if (wide) begin
                    cnt_hi_reg <= high_buf_reg;
                end
            end else if (pre_tick & wide) begin
                low_reg    <= cnt16_inc[7:0];
                cnt_hi_reg <= cnt16_inc[15:8];
            end else if (cnt_evt) begin
                low_reg    <= 8'h00;
                period_reg <= high_buf_reg;
            end else if (pre_tick) begin
                low_reg <= low_reg + 8'h01;
            end
            // The buffer is the only software path to the internal high byte; counting also writes it.
            if (wr_hi) begin
                high_buf_reg <= pwdata[7:0];
            end else if (rd_lo & wide) begin
                high_buf_reg <= cnt_hi_reg;
            end
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_match_clears_low: assert property (
        cnt_evt && !wide && !wr_lo |=> low_reg == 8'h00)
        else $error("low count not cleared on match");

    a_period_reload: assert property (
        cnt_evt && !wide && !wr_lo && !wr_hi
        |=> period_reg == $past(high_buf_reg))
        else $error("period buffer not reloaded on match");

    a_pulse_holds: assert property (
        out_reg && !pre_tick && ctrl1_reg.enable && !post_hit
        |=> out_reg)
        else $error("output pulse ended early");

    a_pulse_ends: assert property (
        out_reg && pre_tick && !post_hit |=> !out_reg)
        else $error("output pulse longer than one period");

    a_wide_increment: assert property (
        pre_tick && wide && !wr_lo
        |=> cnt16 == $past(cnt16) + 16'h0001)
        else $error("16-bit count did not increment");

    a_read_copy_high: assert property (
        rd_lo && wide |=> high_buf_reg == $past(cnt_hi_reg))
        else $error("high byte not copied on low read");

    a_write_loads_high: assert property (
        wr_lo && wide |=> cnt_hi_reg == $past(high_buf_reg)
                          && low_reg == $past(pwdata[7:0]))
        else $error("16-bit write not applied at once");

    a_scaler_clear: assert property (
        clr_scale |=> presc_reg == 15'h0000 && post_reg == 4'h0)
        else $error("scalers not cleared by write");

    a_no_prescale: assert property (
        ctrl2_reg.prescale_ratio_field == 4'h0 |-> pre_tick == src_tick)
        else $error("prescale zero must not divide");

    a_sync_sleep: assert property (
        sleep_in && !async_on |-> !src_tick)
        else $error("sync count advanced in sleep");

    // A set only has to win in its own cycle, so the flag checks allow a
    // software clear in the very next cycle.
    a_flag_sticky: assert property (
        post_hit |=> flag_reg)
        else $error("flag not set by output pulse");

    a_flag_holds: assert property (
        flag_reg && !flag_clr |=> flag_reg)
        else $error("flag dropped without a clear");

    a_flag_clears: assert property (
        flag_clr && !post_hit |=> !flag_reg)
        else $error("flag not cleared by software");

    a_pulse_starts: assert property (
        post_hit |=> out_reg)
        else $error("output pulse missing after match");

    a_out_disabled: assert property (
        !ctrl1_reg.enable |=> !out_reg)
        else $error("output high while timer disabled");

    a_width_select_write: assert property (
        wr_c1 |=> wide == $past(pwdata[4]))
        else $error("width select not written");

    a_low_direct: assert property (
        wr_lo && !wide |=> low_reg == $past(pwdata[7:0]))
        else $error("low count write not applied");

    a_high_buffer_write: assert property (
        wr_hi |=> high_buf_reg == $past(pwdata[7:0]))
        else $error("high buffer write not applied");

    a_high_internal_only: assert property (
        !(wr_lo && wide) && !(pre_tick && wide)
        |=> $stable(cnt_hi_reg))
        else $error("internal high byte changed without cause");

    a_narrow_read_plain: assert property (
        rd_lo && !wide |=> $stable(high_buf_reg))
        else $error("8-bit low read changed the high register");

    a_period_hold: assert property (
        !cnt_evt |=> $stable(period_reg))
        else $error("period buffer changed without a match");

    a_narrow_count: assert property (
        pre_tick && !wide && !wr_lo && !match8
        |=> low_reg == $past(low_reg) + 8'h01)
        else $error("8-bit count did not increment");

    a_count_idle: assert property (
        !pre_tick && !wr_lo |=> $stable(low_reg))
        else $error("low count moved without a tick");

    a_prescale_step: assert property (
        src_tick && !pre_tick && !clr_scale
        |=> presc_reg == $past(presc_reg) + 15'h0001)
        else $error("prescaler did not advance");

    a_prescale_hold: assert property (
        !src_tick && !clr_scale |=> $stable(presc_reg))
        else $error("prescaler moved without a source tick");

    a_sync_rate: assert property (
        src_tick && is_ext && !async_on |-> instr_en)
        else $error("sync count off the instruction cycle");

    a_async_sleep: assert property (
        ext_edge && async_on && is_ext && ctrl1_reg.enable |-> src_tick)
        else $error("async edge not counted");

    a_internal_tick: assert property (
        ctrl1_reg.enable && !sleep_in && src_sel == SRC_FOSC |-> src_tick)
        else $error("internal source did not tick");

endmodule : tmrcnt_top

`default_nettype wire
